// [qdd_cmd_decoder.sv]
// Command decoder top: link crossing, address match and load command execution
`timescale 1ns/1ps
module qdd_cmd_decoder import qdd_pkg::*; (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        link_sclk,
  input  wire logic        frame_sel_n,
  input  wire logic        ser_din,
  input  wire logic        addr_strap_high,
  input  wire logic        addr_strap_low,
  output logic [15:0]      ch_code_a,
  output logic [15:0]      ch_code_b,
  output logic [15:0]      ch_code_c,
  output logic [15:0]      ch_code_d,
  output logic [1:0]       ch_pwrdn_a,
  output logic [1:0]       ch_pwrdn_b,
  output logic [1:0]       ch_pwrdn_c,
  output logic [1:0]       ch_pwrdn_d,
  output logic             cmd_accept,
  output logic             cmd_ignored
);
  typedef struct packed {
    logic       tgl_s1;
    logic       tgl_s2;
    logic       tgl_seen;
    logic [1:0] strap_s1;
    logic [1:0] strap_s2;
    logic       accept;
    logic       ignored;
  } qdd_dec_st_t;

  qdd_dec_st_t          st_reg, st_next;
  logic [WORD_BITS-1:0] rx_word;
  logic                 rx_tgl;
  qdd_bank_t            stg_q;
  qdd_bank_t            dac_q;
  qdd_bank_t            stg_wd;
  qdd_bank_t            dac_wd;
  logic [NUM_CH-1:0]    stg_we;
  logic [NUM_CH-1:0]    dac_we;
  logic                 go;
  logic                 match;
  logic                 bcast;
  logic                 act;
  qdd_load_t            ld;
  logic [1:0]           sel;
  logic [REG_W-1:0]     entry;

  // Receiver on the link clock; hands over a word plus an event toggle
  qdd_ser_rx u_rx (
    .link_sclk   (link_sclk),
    .frame_sel_n (frame_sel_n),
    .ser_din     (ser_din),
    .srst        (srst),
    .word_q      (rx_word),
    .lock_tgl    (rx_tgl)
  );

  // Channel register storage
  qdd_chan_bank u_bank (
    .clk    (clk),
    .srst   (srst),
    .stg_we (stg_we),
    .stg_wd (stg_wd),
    .dac_we (dac_we),
    .dac_wd (dac_wd),
    .stg_q  (stg_q),
    .dac_q  (dac_q)
  );

  // Word fields; bit 19 is deliberately never looked at
  always_comb begin
    ld    = qdd_load_t'(rx_word[LD_HI_BIT:LD_LO_BIT]);
    sel   = rx_word[SEL_HI_BIT:SEL_LO_BIT];
    entry = qdd_entry(rx_word);
    bcast = (ld == QDD_LD_BCAST);
    match = (rx_word[ADDR_HI_BIT] == st_reg.strap_s2[1])
         && (rx_word[ADDR_LO_BIT] == st_reg.strap_s2[0]);
  end

  // A toggle edge marks a new word; the word itself is steady for many
  // link periods afterwards, so it is read directly without resampling
  assign go  = st_reg.tgl_s2 ^ st_reg.tgl_seen;
  assign act = go && (match || bcast);

  // Load command execution: every write enable of one word in one cycle
  always_comb begin
    stg_we = '0;
    dac_we = '0;
    stg_wd = '0;
    dac_wd = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      stg_wd[i] = entry;
      dac_wd[i] = entry;
    end
    if (act) begin
      case (ld)
        QDD_LD_STORE: begin
          stg_we[sel] = 1'b1;
        end
        QDD_LD_UPDATE: begin
          stg_we[sel] = 1'b1;
          dac_we[sel] = 1'b1;
        end
        QDD_LD_SIMUL: begin
          stg_we[sel] = 1'b1;
          dac_we      = '1;
          for (int i = 0; i < NUM_CH; i++) begin
            if (i != int'(sel)) begin
              dac_wd[i] = stg_q[i];
            end
          end
        end
        QDD_LD_BCAST: begin
          dac_we = '1;
          if (rx_word[SEL_HI_BIT]) begin
            stg_we = '1;
          end else begin
            dac_wd = stg_q;
          end
        end
        default: begin
          stg_we = '0;
        end
      endcase
    end
  end

  // Crossing and strap synchronisers; the first stages feed only the second
  always_comb begin
    st_next          = st_reg;
    st_next.tgl_s1   = rx_tgl;
    st_next.tgl_s2   = st_reg.tgl_s1;
    st_next.tgl_seen = st_reg.tgl_s2;
    st_next.strap_s1 = {addr_strap_high, addr_strap_low};
    st_next.strap_s2 = st_reg.strap_s1;
    st_next.accept   = act;
    st_next.ignored  = go && !act;
  end

  // Synchronous reset to a quiet state
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the output code registers and the accept and ignored flag registers
  assign ch_code_a   = dac_q[0][15:0];
  assign ch_code_b   = dac_q[1][15:0];
  assign ch_code_c   = dac_q[2][15:0];
  assign ch_code_d   = dac_q[3][15:0];
  assign ch_pwrdn_a  = dac_q[0][17:16];
  assign ch_pwrdn_b  = dac_q[1][17:16];
  assign ch_pwrdn_c  = dac_q[2][17:16];
  assign ch_pwrdn_d  = dac_q[3][17:16];
  assign cmd_accept  = st_reg.accept;
  assign cmd_ignored = st_reg.ignored;

  // Checks on the applied effect of each word, one cycle after the event

  a_mismatch_quiet: assert property (@(posedge clk) disable iff (srst)
    go && !match && !bcast |=> $stable(stg_q) && $stable(dac_q) && cmd_ignored)
    else $error("unaddressed word changed a register");

  a_store_only: assert property (@(posedge clk) disable iff (srst)
    go && match && ld == QDD_LD_STORE
    |=> $stable(dac_q) && stg_q[$past(sel)] == $past(entry))
    else $error("store touched an output register or missed staging");

  a_update_both: assert property (@(posedge clk) disable iff (srst)
    go && match && ld == QDD_LD_UPDATE
    |=> dac_q[$past(sel)] == $past(entry) && stg_q[$past(sel)] == $past(entry))
    else $error("update did not load both registers");

  a_simul_others: assert property (@(posedge clk) disable iff (srst)
    go && match && ld == QDD_LD_SIMUL
    |=> dac_q[$past(sel)] == $past(entry)
        && dac_q[$past(sel) + 2'd1] == $past(stg_q[sel + 2'd1])
        && dac_q[$past(sel) + 2'd2] == $past(stg_q[sel + 2'd2])
        && dac_q[$past(sel) + 2'd3] == $past(stg_q[sel + 2'd3]))
    else $error("simultaneous update loaded a wrong channel");

  a_bcast_copy: assert property (@(posedge clk) disable iff (srst)
    go && bcast && !rx_word[SEL_HI_BIT]
    |=> dac_q == $past(stg_q) && $stable(stg_q))
    else $error("broadcast copy did not move staging to outputs");

  a_bcast_data: assert property (@(posedge clk) disable iff (srst)
    go && bcast && rx_word[SEL_HI_BIT]
    |=> dac_q == {NUM_CH{$past(entry)}} && stg_q == {NUM_CH{$past(entry)}})
    else $error("broadcast data did not reach all channels");

  a_bcast_any_addr: assert property (@(posedge clk) disable iff (srst)
    go && bcast |=> cmd_accept)
    else $error("broadcast refused on address");

  a_pd_mode_map: assert property (@(posedge clk) disable iff (srst)
    go && match && ld == QDD_LD_UPDATE && rx_word[PD_FLAG_BIT]
    |=> dac_q[$past(sel)][17:16] ==
        ($past(rx_word[15:14]) == 2'b01 ? PD_1K :
         $past(rx_word[15:14]) == 2'b10 ? PD_100K : PD_HIZ))
    else $error("power-down mode mapped wrongly");

  a_data_wakes: assert property (@(posedge clk) disable iff (srst)
    go && match && ld == QDD_LD_UPDATE && !rx_word[PD_FLAG_BIT]
    |=> dac_q[$past(sel)][17:16] == PD_ON)
    else $error("data load left the channel powered down");

  a_event_once: assert property (@(posedge clk) disable iff (srst)
    go |=> !go ##0 (cmd_accept ^ cmd_ignored) ##1 !cmd_accept && !cmd_ignored)
    else $error("one word produced more than one event");
endmodule

// [qdd_pkg.sv]
// Shared constants, types and decode function of the quad converter command decoder
// Behaviour
// - Word is 24 bits: control 23-16, data 15-0.
// - Bits 23 and 22 compared with address straps.
// - Address mismatch, not broadcast: change nothing.
// - Bits 21 and 20 form the load command.
// - Bit 19 is ignored entirely.
// - Bits 18 and 17 select channel A to D.
// - Load 00 writes staging register only.
// - Load 01 writes staging and output registers.
// - Load 10 loads selected, others from staging.
// - Load 11 is broadcast, straps ignored.
// - Broadcast, bit 18 clear: all outputs from staging.
// - Broadcast, bit 18 set: word loads all channels.
// - Bit 16 set makes bits 15-14 power-down mode.
// - Mode 00/11 high-Z, 01 1k, 10 100k.
// - Power-down stored and applied exactly like data.
// - MSB first, falling edges, lock at 24th.
// - Early frame end resets receiver, no update.
// - Channel registers are 18 bits wide.
// - Loading plain data leaves power-down automatically.
package qdd_pkg;
  localparam int          WORD_BITS   = 24;
  localparam int          NUM_CH      = 4;
  localparam int          REG_W       = 18;
  localparam int          CNT_W       = 5;
  localparam logic [4:0]  CNT_LAST    = 5'h17;  // Edge count before the 24th edge
  localparam logic [4:0]  CNT_LOCK    = 5'h18;  // Count once the word is locked
  localparam int          ADDR_HI_BIT = 23;
  localparam int          ADDR_LO_BIT = 22;
  localparam int          LD_HI_BIT   = 21;
  localparam int          LD_LO_BIT   = 20;
  localparam int          SEL_HI_BIT  = 18;
  localparam int          SEL_LO_BIT  = 17;
  localparam int          PD_FLAG_BIT = 16;
  localparam int          PD_MODE_HI  = 15;
  localparam int          PD_MODE_LO  = 14;
  localparam int          DATA_MSB    = 15;
  localparam logic [17:0] REG_RST     = 18'h00000;
  // Stored power state in bits 17:16 of a channel register
  localparam logic [1:0]  PD_ON       = 2'h0;
  localparam logic [1:0]  PD_1K       = 2'h1;
  localparam logic [1:0]  PD_100K     = 2'h2;
  localparam logic [1:0]  PD_HIZ      = 2'h3;

  typedef enum logic [1:0] {
    QDD_LD_STORE  = 2'b00,
    QDD_LD_UPDATE = 2'b01,
    QDD_LD_SIMUL  = 2'b10,
    QDD_LD_BCAST  = 2'b11
  } qdd_load_t;

  typedef logic [NUM_CH-1:0][REG_W-1:0] qdd_bank_t;

  // Channel register image of a word: power state over the sixteen data bits
  function automatic logic [REG_W-1:0] qdd_entry(input logic [WORD_BITS-1:0] w);
    logic [1:0] pd;
    pd = PD_ON;
    if (w[PD_FLAG_BIT]) begin
      case ({w[PD_MODE_HI], w[PD_MODE_LO]})
        2'b01:   pd = PD_1K;
        2'b10:   pd = PD_100K;
        default: pd = PD_HIZ;
      endcase
    end
    return {pd, w[DATA_MSB:0]};
  endfunction
endpackage

// [qdd_ser_rx.sv]
// Serial word receiver running on the link clock
`timescale 1ns/1ps
module qdd_ser_rx import qdd_pkg::*; (
  input  wire logic                 link_sclk,
  input  wire logic                 frame_sel_n,
  input  wire logic                 ser_din,
  input  wire logic                 srst,
  output logic [WORD_BITS-1:0]      word_q,
  output logic                      lock_tgl
);
  typedef struct packed {
    logic [CNT_W-1:0]     cnt;
    logic [WORD_BITS-1:0] shift;
  } qdd_rx_t;
  typedef struct packed {
    logic [WORD_BITS-1:0] word;
    logic                 tgl;
  } qdd_cap_t;

  qdd_rx_t  rx_reg, rx_next;
  qdd_cap_t cap_reg, cap_next;

  // Shift MSB first until 24 bits are in, then hold; the 24th edge toggles the event
  always_comb begin
    rx_next  = rx_reg;
    cap_next = cap_reg;
    if (rx_reg.cnt != CNT_LOCK) begin
      rx_next.shift = {rx_reg.shift[WORD_BITS-2:0], ser_din};
      rx_next.cnt   = rx_reg.cnt + 5'h01;
    end
    if (rx_reg.cnt == CNT_LAST) begin
      cap_next.word = {rx_reg.shift[WORD_BITS-2:0], ser_din};
      cap_next.tgl  = ~cap_reg.tgl;
    end
  end

  // Frame select high clears the receiver at once, since the clock stops between frames;
  // reset clears it too, so a frame select that is already high at power-on leaves no unknown
  always_ff @(negedge link_sclk or posedge frame_sel_n or posedge srst) begin
    if (frame_sel_n || srst) begin
      rx_reg <= '0;
    end else begin
      rx_reg <= rx_next;
    end
  end

  // Captured word survives frame end; it only changes at the next 24th edge
  always_ff @(negedge link_sclk or posedge srst) begin
    if (srst) begin
      cap_reg <= '0;
    end else begin
      cap_reg <= cap_next;
    end
  end

  assign word_q   = cap_reg.word;
  assign lock_tgl = cap_reg.tgl;

  a_lock_holds: assert property (@(negedge link_sclk) disable iff (frame_sel_n)
    rx_reg.cnt == CNT_LOCK |=> rx_reg.cnt == CNT_LOCK && $stable(cap_reg))
    else $error("receiver changed after the word was locked");
endmodule

// [qdd_chan_bank.sv]
// Staging and output code registers of the four channels
`timescale 1ns/1ps
module qdd_chan_bank import qdd_pkg::*; (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic [NUM_CH-1:0]    stg_we,
  input  wire qdd_bank_t            stg_wd,
  input  wire logic [NUM_CH-1:0]    dac_we,
  input  wire qdd_bank_t            dac_wd,
  output qdd_bank_t                 stg_q,
  output qdd_bank_t                 dac_q
);
  typedef struct packed {
    qdd_bank_t stg;
    qdd_bank_t dac;
  } qdd_bank_st_t;

  qdd_bank_st_t st_reg, st_next;

  // Per-channel write, both banks in the same edge
  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < NUM_CH; i++) begin
      if (stg_we[i]) begin
        st_next.stg[i] = stg_wd[i];
      end
      if (dac_we[i]) begin
        st_next.dac[i] = dac_wd[i];
      end
    end
  end

  // Reset stands for power-on: zero code, outputs active
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= {(2 * NUM_CH){REG_RST}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign stg_q = st_reg.stg;
  assign dac_q = st_reg.dac;
endmodule

// [qdd_host_model.sv]
// Host-side model that drives three-wire serial frames into the decoder
`timescale 1ns/1ps
module qdd_host_model (
  output logic link_sclk,
  output logic frame_sel_n,
  output logic ser_din
);
  // Link clock stands still low between frames
  initial begin
    link_sclk   = 1'b0;
    frame_sel_n = 1'b1;
    ser_din     = 1'b0;
  end

  // Sends nb bits MSB first at a 48 ns link period; bits past 24 are filler
  task automatic send_frame(input logic [23:0] w, input int nb);
    frame_sel_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      link_sclk = 1'b1;
      ser_din   = (i < 24) ? w[23-i] : ~ser_din;
      #24;
      link_sclk = 1'b0;
      #24;
    end
    // Released data line shows the inverse so a stale bit cannot pass
    ser_din = ~ser_din;
    #24;
    frame_sel_n = 1'b1;
    #160;
  endtask
endmodule

// [quad_dac_command_decoder_tb_top.sv]
// Self-checking bench of the quad converter command decoder
`timescale 1ns/1ps
module quad_dac_command_decoder_tb_top import qdd_pkg::*;;
  logic        clk = 1'b0;
  logic        srst = 1'b0;
  logic        strap_hi = 1'b0;
  logic        strap_lo = 1'b0;
  logic        link_sclk;
  logic        frame_sel_n;
  logic        ser_din;
  logic [15:0] code [4];
  logic [1:0]  pwr [4];
  logic        cmd_accept;
  logic        cmd_ignored;
  logic [17:0] stg [4];
  logic [17:0] dac [4];
  int          errors = 0;
  int          cmp_count = 0;
  int          acc_n = 0;
  int          ign_n = 0;

  always #4 clk = ~clk;

  qdd_host_model host (
    .link_sclk   (link_sclk),
    .frame_sel_n (frame_sel_n),
    .ser_din     (ser_din)
  );

  qdd_cmd_decoder dut (
    .clk (clk), .srst (srst), .link_sclk (link_sclk), .frame_sel_n (frame_sel_n),
    .ser_din (ser_din), .addr_strap_high (strap_hi), .addr_strap_low (strap_lo),
    .ch_code_a (code[0]), .ch_code_b (code[1]), .ch_code_c (code[2]), .ch_code_d (code[3]),
    .ch_pwrdn_a (pwr[0]), .ch_pwrdn_b (pwr[1]), .ch_pwrdn_c (pwr[2]), .ch_pwrdn_d (pwr[3]),
    .cmd_accept (cmd_accept), .cmd_ignored (cmd_ignored)
  );

  // Pulse counters: a pulse stretched past one cycle shows as an extra count
  always @(posedge clk) begin
    if (cmd_accept === 1'b1)
      acc_n++;
    if (cmd_ignored === 1'b1)
      ign_n++;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic logic [23:0] word(input logic [1:0] a, input logic [1:0] ld,
                                       input logic [1:0] ch, input logic pd,
                                       input logic [15:0] d);
    return {a, ld, 1'b0, ch, pd, d};
  endfunction

  // Expected channel image: power state over the data bits
  function automatic logic [17:0] entry(input logic [23:0] w);
    logic [1:0] pd;
    pd = PD_ON;
    if (w[16])
      pd = (w[15:14] == 2'h1) ? PD_1K : (w[15:14] == 2'h2) ? PD_100K : PD_HIZ;
    return {pd, w[15:0]};
  endfunction

  task automatic check_all();
    for (int k = 0; k < 4; k++)
      check($sformatf("channel %0d", k), {14'h0, pwr[k], code[k]}, {14'h0, dac[k]});
  endtask

  // Updates the reference model, sends the frame, then judges pulses and outputs
  task automatic run(input logic [23:0] w, input int nb);
    logic       hit;
    logic [1:0] ld;
    int         ch;
    int         a0;
    int         i0;
    ld  = w[21:20];
    ch  = w[18:17];
    hit = (ld == 2'h3) || (w[23] === strap_hi && w[22] === strap_lo);
    if (nb >= 24 && hit) begin
      case (ld)
        2'h0: stg[ch] = entry(w);
        2'h1: begin
          stg[ch] = entry(w);
          dac[ch] = entry(w);
        end
        2'h2: begin
          stg[ch] = entry(w);
          for (int k = 0; k < 4; k++)
            dac[k] = stg[k];
        end
        default: begin
          for (int k = 0; k < 4; k++) begin
            if (w[18])
              stg[k] = entry(w);
            dac[k] = stg[k];
          end
        end
      endcase
    end
    a0 = acc_n;
    i0 = ign_n;
    host.send_frame(w, nb);
    check("accept pulses", acc_n - a0, (nb >= 24 && hit) ? 1 : 0);
    check("ignored pulses", ign_n - i0, (nb >= 24 && !hit) ? 1 : 0);
    check_all();
  endtask

  task automatic set_straps(input logic h, input logic l);
    @(posedge clk);
    #1;
    strap_hi = h;
    strap_lo = l;
    repeat (4) @(posedge clk);
  endtask

  task automatic t_store();
    for (int c = 0; c < 4; c++)
      run(word(2'h0, 2'h0, 2'(c), 1'b0, 16'(16'h1111 * (c + 1))), 24);
    run(word(2'h0, 2'h1, 2'h1, 1'b0, 16'hBEEF) ^ 24'h080000, 24);
  endtask

  task automatic t_pdmodes();
    for (int m = 0; m < 4; m++)
      run(word(2'h0, 2'h1, 2'h0, 1'b1, {2'(m), 14'h2AA}), 24);
    run(word(2'h0, 2'h1, 2'h0, 1'b0, 16'h1234), 24);
  endtask

  task automatic t_simul();
    run(word(2'h0, 2'h0, 2'h1, 1'b1, 16'h4000), 24);
    run(word(2'h0, 2'h0, 2'h3, 1'b1, 16'h8000), 24);
    run(word(2'h0, 2'h2, 2'h2, 1'b0, 16'h5A5A), 24);
  endtask

  task automatic t_addr();
    set_straps(1'b1, 1'b0);
    run(word(2'h1, 2'h1, 2'h3, 1'b0, 16'h7777), 24);
    run(word(2'h3, 2'h2, 2'h0, 1'b0, 16'h6666), 24);
    run(word(2'h2, 2'h0, 2'h3, 1'b0, 16'h3C3C), 24);
    run(word(2'h1, 2'h3, 2'h0, 1'b0, 16'hFFFF), 24);
    run(word(2'h0, 2'h3, 2'h2, 1'b1, 16'h8000), 24);
    run(word(2'h3, 2'h3, 2'h2, 1'b0, 16'hC3C3), 24);
  endtask

  task automatic t_frames();
    run(word(2'h2, 2'h1, 2'h0, 1'b0, 16'h0F0F), 23);
    run(word(2'h2, 2'h1, 2'h1, 1'b0, 16'hA5A5), 26);
  endtask

  // Watchdog: the frames need about 30 us
  initial begin
    #100000;
    errors++;
    wrap_up();
  end

  initial begin
    for (int k = 0; k < 4; k++) begin
      stg[k] = REG_RST;
      dac[k] = REG_RST;
    end
    // A real rising edge, so the link-side flops see their asynchronous clear
    #1;
    srst = 1'b1;
    repeat (16) @(posedge clk);
    #1;
    srst = 1'b0;
    @(posedge clk);
    #1;
    check_all();
    t_store();
    t_pdmodes();
    t_simul();
    t_addr();
    t_frames();
    wrap_up();
  end
endmodule
